// *** hdl/int_arb_cfg.svh ***
// Constants for the priority interrupt arbiter
`ifndef INT_ARB_CFG_SVH
`define INT_ARB_CFG_SVH

`define CH_COUNT 14
`define CH_MAX 16
`define PRIO_W 3
`define CPL_RESET 3'h7
`define PRIO_LOWEST 3'h7
`define NEST_RESET 8'h00
`define IEN_RESET 1'b0
`define CS_RESET 8'h00
`define TOP_VECTOR 8'h04
`define VEC_BASE_LSB 5
`define VEC_IDX_LSB 1

`endif

// *** hdl/int_arb_pkg.sv ***
// Types shared by the priority interrupt arbiter modules
`default_nettype none
`include "int_arb_cfg.svh"
package int_arb_pkg;
	typedef logic [`PRIO_W-1:0] prio_t;
	typedef logic [3:0] chan_idx_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_PUSH_PCL = 4'h1,
		ST_PUSH_PCH = 4'h2,
		ST_PUSH_CS = 4'h3,
		ST_PUSH_FLAG = 4'h4,
		ST_VECTOR = 4'h5,
		ST_POP_FLAG = 4'h6,
		ST_POP_CS = 4'h7,
		ST_POP_PCH = 4'h8,
		ST_POP_PCL = 4'h9,
		ST_RET_DONE = 4'ha
	} seq_state_t;
endpackage : int_arb_pkg
`default_nettype wire

// *** hdl/arb_if.sv ***
// Request and winner signals between the sequencer and the chain arbiter
`timescale 1ns/1ps
`default_nettype none
`include "int_arb_cfg.svh"
interface arb_if import int_arb_pkg::*; #(parameter int N = `CH_COUNT);
	logic [N-1:0] req;
	logic [N*`PRIO_W-1:0] prio;
	logic win_valid;
	chan_idx_t win_idx;
	prio_t win_prio;
	modport arb (input req, input prio, output win_valid, output win_idx, output win_prio);
	modport user (output req, output prio, input win_valid, input win_idx, input win_prio);
endinterface : arb_if
`default_nettype wire

// *** hdl/chain_arbiter.sv ***
// Lowest priority value wins; ties go to the lowest channel index
`timescale 1ns/1ps
`default_nettype none
`include "int_arb_cfg.svh"
module chain_arbiter import int_arb_pkg::*; #(parameter int N = `CH_COUNT) (
	arb_if.arb bus
);
	logic valid;
	chan_idx_t idx;
	prio_t best;

	// Scan from the tail so an equal level nearer the head replaces it
	always_comb begin
		valid = 1'b0;
		idx = 4'h0;
		best = `PRIO_LOWEST;
		for (int i = N - 1; i >= 0; i--) begin
			if (bus.req[i] && (!valid || bus.prio[i*`PRIO_W +: `PRIO_W] <= best)) begin
				valid = 1'b1;
				idx = 4'(i);
				best = bus.prio[i*`PRIO_W +: `PRIO_W];
			end
		end
	end

	assign bus.win_valid = valid;
	assign bus.win_idx = idx;
	assign bus.win_prio = best;
endmodule : chain_arbiter
`default_nettype wire

// *** hdl/priority_interrupt_arbiter.sv ***
// Priority interrupt arbiter with entry and return stacking sequencer
// Summary of operation
// - Save off: use interrupt segment, stack PC, flags
// - Save on: push code segment, load from interrupt
// - Save on: return restores code segment from stack
// - Each channel has 3-bit priority, 0 highest
// - Top level request overrides, never interrupted, maskable option
// - Current priority level resets to seven
// - Software may read and write current level
// - Every instruction compares all interrupt and DMA requests
// - Acknowledge only when priority above current level
// - Priority seven requests never acknowledged
// - Nested: equal level never interrupts running routine
// - Fixed chain order breaks priority ties
// - Mode bit picks concurrent or nested arbitration
// - Concurrent mode leaves current level unchanged
// - Entry: disable, push PC low, high, segment, flags
// - Return: pop flags, segment, PC high, low; enable
// - Channel and maskable top requests wait while global enable is clear; DMA and nonmaskable top do not
// - Concurrent: enabled routine accepts any higher request
// - Vector: software base high bits, channel low bits
// - Vector table in interrupt segment first 256 bytes
// - Nested: mark old level, load acknowledged priority
`timescale 1ns/1ps
`default_nettype none
`include "int_arb_cfg.svh"
module priority_interrupt_arbiter import int_arb_pkg::*; #(
	parameter int NUM_CH = `CH_COUNT
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic instr_boundary,
	input wire logic [NUM_CH-1:0] irq_pending,
	input wire logic [NUM_CH-1:0] dma_pending,
	input wire logic [NUM_CH*`PRIO_W-1:0] channel_priority_field,
	input wire logic top_level_req,
	input wire logic top_level_maskable,
	input wire logic top_level_nonmaskable,
	input wire logic arbitration_mode_select,
	input wire logic segment_save_enable,
	input wire logic enable_interrupts_op,
	input wire logic cpl_wr,
	input wire logic [`PRIO_W-1:0] cpl_wdata,
	input wire logic [7:0] vector_select_reg,
	input wire logic iret_req,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] flag_reg,
	input wire logic cs_wr,
	input wire logic [7:0] cs_wdata,
	input wire logic [7:0] interrupt_segment_reg,
	input wire logic [7:0] stack_rdata,
	output logic int_ack,
	output logic dma_grant,
	output logic [3:0] grant_channel,
	output logic ack_top_level,
	output logic [7:0] int_vector,
	output logic vec_fetch,
	output logic stack_push,
	output logic stack_pop,
	output logic [7:0] stack_wdata,
	output logic global_int_enable,
	output logic [`PRIO_W-1:0] current_priority_level,
	output logic [7:0] nesting_priority_stack,
	output logic [7:0] code_segment_reg,
	output logic [7:0] fetch_segment,
	output logic ret_done,
	output logic [15:0] ret_pc,
	output logic [7:0] ret_flags
);

	generate
		if (NUM_CH < 1 || NUM_CH > `CH_MAX) begin : g_bad_count
			$error("NUM_CH must be 1 to 16");
		end
	endgenerate

	seq_state_t state_ff, nxt_state;
	prio_t cpl_ff;
	logic [7:0] nest_ff;
	logic ien_ff;
	logic in_top_ff;
	logic use_isr_ff;
	logic [7:0] cs_ff;
	logic [7:0] vec_ff;
	chan_idx_t chan_ff;
	logic top_ff;
	logic [7:0] wdata_ff;
	logic [7:0] pc_hi_ff;
	logic [7:0] flag_ff;
	logic [15:0] ret_pc_ff;
	logic [7:0] ret_flags_ff;
	logic idle, iret_go, top_go, int_go, dma_go, ack_go;
	logic win_irq;

	arb_if #(.N(NUM_CH)) arb_bus ();

	chain_arbiter #(.N(NUM_CH)) u_chain (
		.bus(arb_bus)
	);

	assign arb_bus.req = irq_pending | dma_pending;
	assign arb_bus.prio = channel_priority_field;

	// Pending requests are levels held by their sources until acknowledged
	assign idle = state_ff == ST_IDLE;
	assign iret_go = idle && iret_req;
	assign win_irq = arb_bus.win_valid && irq_pending[arb_bus.win_idx];
	assign top_go = idle && !iret_req && instr_boundary && !in_top_ff && top_level_req &&
		(top_level_nonmaskable || (top_level_maskable && ien_ff));
	assign int_go = idle && !iret_req && instr_boundary && !in_top_ff && !top_go && ien_ff &&
		win_irq && (arb_bus.win_prio < cpl_ff);
	assign dma_go = idle && !iret_req && instr_boundary && !top_go && arb_bus.win_valid &&
		!win_irq;
	assign ack_go = top_go || int_go;

	// Returns the most recently saved level of the nesting stack
	function automatic prio_t lowest_set(input logic [7:0] v);
		prio_t r;
		r = `PRIO_LOWEST;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : lowest_set

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (iret_go) begin
					nxt_state = ST_POP_FLAG;
				end else if (ack_go) begin
					nxt_state = ST_PUSH_PCL;
				end
			end
			ST_PUSH_PCL: nxt_state = ST_PUSH_PCH;
			ST_PUSH_PCH: nxt_state = segment_save_enable ? ST_PUSH_CS : ST_PUSH_FLAG;
			ST_PUSH_CS: nxt_state = ST_PUSH_FLAG;
			ST_PUSH_FLAG: nxt_state = ST_VECTOR;
			ST_VECTOR: nxt_state = ST_IDLE;
			ST_POP_FLAG: nxt_state = segment_save_enable ? ST_POP_CS : ST_POP_PCH;
			ST_POP_CS: nxt_state = ST_POP_PCH;
			ST_POP_PCH: nxt_state = ST_POP_PCL;
			ST_POP_PCL: nxt_state = ST_RET_DONE;
			ST_RET_DONE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Global enable: cleared on entry, set by return or enable op
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ien_ff <= `IEN_RESET;
		end else if (ack_go) begin
			ien_ff <= 1'b0;
		end else if (state_ff == ST_RET_DONE || enable_interrupts_op) begin
			ien_ff <= 1'b1;
		end
	end

	// Current level and nesting stack
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpl_ff <= `CPL_RESET;
			nest_ff <= `NEST_RESET;
		end else if (int_go && arbitration_mode_select) begin
			nest_ff[cpl_ff] <= 1'b1;
			cpl_ff <= arb_bus.win_prio;
		end else if (state_ff == ST_RET_DONE && arbitration_mode_select && !in_top_ff &&
			nest_ff != `NEST_RESET) begin
			cpl_ff <= lowest_set(nest_ff);
			nest_ff[lowest_set(nest_ff)] <= 1'b0;
		end else if (cpl_wr) begin
			cpl_ff <= cpl_wdata;
		end
	end

	// A top level routine runs until its own return
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			in_top_ff <= 1'b0;
		end else if (top_go) begin
			in_top_ff <= 1'b1;
		end else if (state_ff == ST_RET_DONE) begin
			in_top_ff <= 1'b0;
		end
	end

	// Code segment and the interrupt segment substitution
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cs_ff <= `CS_RESET;
			use_isr_ff <= 1'b0;
		end else if (state_ff == ST_VECTOR) begin
			if (segment_save_enable) begin
				cs_ff <= interrupt_segment_reg;
			end else begin
				use_isr_ff <= 1'b1;
			end
		end else if (state_ff == ST_POP_CS) begin
			cs_ff <= stack_rdata;
		end else if (state_ff == ST_RET_DONE) begin
			if (!segment_save_enable) begin
				use_isr_ff <= 1'b0;
			end
		end else if (cs_wr) begin
			cs_ff <= cs_wdata;
		end
	end

	// Vector held from acknowledge until the next one; channel also reloads on a DMA grant
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			vec_ff <= `TOP_VECTOR;
			chan_ff <= 4'h0;
			top_ff <= 1'b0;
		end else if (ack_go) begin
			top_ff <= top_go;
			chan_ff <= arb_bus.win_idx;
			if (top_go) begin
				vec_ff <= `TOP_VECTOR;
			end else begin
				vec_ff <= {vector_select_reg[7:`VEC_BASE_LSB], arb_bus.win_idx, 1'b0};
			end
		end else if (dma_go) begin
			chan_ff <= arb_bus.win_idx;
		end
	end

	// Stack write data, one byte ahead of each push cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wdata_ff <= 8'h00;
			pc_hi_ff <= 8'h00;
			flag_ff <= 8'h00;
		end else if (ack_go) begin
			wdata_ff <= pc_in[7:0];
			pc_hi_ff <= pc_in[15:8];
			flag_ff <= flag_reg;
		end else if (state_ff == ST_PUSH_PCL) begin
			wdata_ff <= pc_hi_ff;
		end else if (state_ff == ST_PUSH_PCH) begin
			wdata_ff <= segment_save_enable ? cs_ff : flag_ff;
		end else if (state_ff == ST_PUSH_CS) begin
			wdata_ff <= flag_ff;
		end
	end

	// Restored program state collected from the pops
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ret_pc_ff <= 16'h0000;
			ret_flags_ff <= 8'h00;
		end else if (state_ff == ST_POP_FLAG) begin
			ret_flags_ff <= stack_rdata;
		end else if (state_ff == ST_POP_PCH) begin
			ret_pc_ff[15:8] <= stack_rdata;
		end else if (state_ff == ST_POP_PCL) begin
			ret_pc_ff[7:0] <= stack_rdata;
		end
	end

	assign int_ack = ack_go;
	assign dma_grant = dma_go;
	assign grant_channel = chan_ff;
	assign ack_top_level = top_ff;
	assign int_vector = vec_ff;
	assign vec_fetch = state_ff == ST_VECTOR;
	assign stack_push = state_ff inside {ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_CS, ST_PUSH_FLAG};
	assign stack_pop = state_ff inside {ST_POP_FLAG, ST_POP_CS, ST_POP_PCH, ST_POP_PCL};
	assign stack_wdata = wdata_ff;
	assign global_int_enable = ien_ff;
	assign current_priority_level = cpl_ff;
	assign nesting_priority_stack = nest_ff;
	assign code_segment_reg = cs_ff;
	// The vector itself is always read from the interrupt segment table
	assign fetch_segment = (use_isr_ff || vec_fetch) ? interrupt_segment_reg : cs_ff;
	assign ret_done = state_ff == ST_RET_DONE;
	assign ret_pc = ret_pc_ff;
	assign ret_flags = ret_flags_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	ack_prio_a: assert property (int_ack && !top_go |-> arb_bus.win_prio < cpl_ff)
		else $error("interrupt acknowledged at or below current level");
	no_level7_a: assert property (int_ack && !top_go |-> arb_bus.win_prio != `PRIO_LOWEST)
		else $error("priority seven request acknowledged");
	top_block_a: assert property (in_top_ff |-> !int_ack)
		else $error("top level routine interrupted");
	pending_hold_a: assert property (!global_int_enable && !top_level_req |-> !int_ack)
		else $error("request acknowledged while disabled");
	entry_order_a: assert property (int_ack |=> !global_int_enable && stack_push &&
		stack_wdata == $past(pc_in[7:0]) ##1 stack_push && stack_wdata == $past(pc_in[15:8], 2))
		else $error("entry push order wrong");
	cs_push_a: assert property (int_ack && segment_save_enable |-> ##3 stack_push &&
		stack_wdata == $past(code_segment_reg, 3) ##1 stack_push ##1 vec_fetch ##1
		code_segment_reg == $past(interrupt_segment_reg))
		else $error("code segment not saved or loaded");
	no_cs_push_a: assert property (int_ack && !segment_save_enable |-> ##3 stack_push &&
		stack_wdata == $past(flag_reg, 3) ##1 vec_fetch ##1
		fetch_segment == interrupt_segment_reg)
		else $error("flags not pushed third or segment not swapped");
	concur_cpl_a: assert property (int_ack && !arbitration_mode_select && !cpl_wr |=>
		$stable(current_priority_level))
		else $error("current level changed in concurrent mode");
	nested_cpl_a: assert property (int_ack && !top_go && arbitration_mode_select |=>
		current_priority_level == $past(arb_bus.win_prio) &&
		nesting_priority_stack[$past(cpl_ff)])
		else $error("nested entry did not record level");
	ret_seq_a: assert property (iret_req && idle && segment_save_enable |=>
		stack_pop [*4] ##1 ret_done ##1 global_int_enable &&
		code_segment_reg == $past(stack_rdata, 4))
		else $error("return sequence wrong");
	vec_freeze_a: assert property (!idle && !$past(idle) |-> $stable(int_vector) &&
		$stable(grant_channel))
		else $error("vector changed during sequence");
	vec_form_a: assert property (int_ack && !top_go |=> int_vector ==
		{$past(vector_select_reg[7:`VEC_BASE_LSB]), $past(arb_bus.win_idx), 1'b0})
		else $error("vector not built from base and channel");
	vec_seg_a: assert property (vec_fetch |-> fetch_segment == interrupt_segment_reg)
		else $error("vector fetched outside interrupt segment");

	entry_save_c: cover property (int_ack && segment_save_enable ##5 vec_fetch);
	top_mask_c: cover property (int_ack && top_go && !top_level_nonmaskable);
	nested_ack_c: cover property (int_ack && arbitration_mode_select ##[1:20] int_ack);
	top_ack_c: cover property (int_ack && top_go);
	return_c: cover property (iret_req && idle ##[3:6] ret_done);
endmodule : priority_interrupt_arbiter
`default_nettype wire

// *** verification/cpu_stack_model.sv ***
// Behavioural system stack of the CPU core that faces the arbiter
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic [7:0] stack_wdata,
	output logic [7:0] stack_rdata
);
	logic [7:0] mem_ff [0:15];
	logic [3:0] sp_ff;
	// Routines driven by the bench make no far calls, so one segment holds them
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sp_ff <= 4'h0;
		end else if (stack_push) begin
			mem_ff[sp_ff] <= stack_wdata;
			sp_ff <= sp_ff + 4'h1;
		end else if (stack_pop) begin
			sp_ff <= sp_ff - 4'h1;
		end
	end
	// Outside a pop the read lines show the inverse, never a stale byte
	assign stack_rdata = stack_pop ? mem_ff[sp_ff - 4'h1] : ~mem_ff[sp_ff - 4'h1];
endmodule : cpu_stack_model
`default_nettype wire

// *** verification/tb_priority_interrupt_arbiter.sv ***
// Self-checking bench for the priority interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
`include "int_arb_cfg.svh"
module tb_priority_interrupt_arbiter import int_arb_pkg::*; ;
	logic sys_clk = 1'b0, rst = 1'b1, instr_boundary = 1'b0, top_level_req = 1'b0;
	logic top_level_maskable = 1'b0, top_level_nonmaskable = 1'b0, cpl_wr = 1'b0;
	logic arbitration_mode_select = 1'b0, segment_save_enable = 1'b1, enable_interrupts_op = 1'b0;
	logic iret_req = 1'b0, cs_wr = 1'b0, int_ack, dma_grant, ack_top_level, vec_fetch;
	logic stack_push, stack_pop, global_int_enable, ret_done;
	logic [`CH_COUNT-1:0] irq_pending = '0, dma_pending = '0;
	logic [`CH_COUNT*3-1:0] channel_priority_field = '1;
	logic [2:0] cpl_wdata = 3'h0, current_priority_level;
	logic [7:0] vector_select_reg = 8'ha0, flag_reg = 8'h81, cs_wdata = 8'h3c;
	logic [7:0] interrupt_segment_reg = 8'h5a, stack_rdata, int_vector, stack_wdata;
	logic [7:0] nesting_priority_stack, code_segment_reg, fetch_segment, ret_flags, fa, fb;
	logic [15:0] pc_in = 16'h1234, ret_pc, pa, pb;
	logic [3:0] grant_channel;
	int bad_count = 0, comparisons = 0;

	always #25 sys_clk = ~sys_clk;

	priority_interrupt_arbiter #(.NUM_CH(`CH_COUNT)) i_priority_interrupt_arbiter (
		.sys_clk, .rst, .instr_boundary, .irq_pending, .dma_pending, .channel_priority_field,
		.top_level_req, .top_level_maskable, .top_level_nonmaskable, .arbitration_mode_select,
		.segment_save_enable, .enable_interrupts_op, .cpl_wr, .cpl_wdata, .vector_select_reg,
		.iret_req, .pc_in, .flag_reg, .cs_wr, .cs_wdata, .interrupt_segment_reg, .stack_rdata,
		.int_ack, .dma_grant, .grant_channel, .ack_top_level, .int_vector, .vec_fetch,
		.stack_push, .stack_pop, .stack_wdata, .global_int_enable, .current_priority_level,
		.nesting_priority_stack, .code_segment_reg, .fetch_segment, .ret_done, .ret_pc, .ret_flags
	);

	cpu_stack_model i_cpu_stack_model (
		.sys_clk, .rst, .stack_push, .stack_pop, .stack_wdata, .stack_rdata
	);

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic test_done;
		if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic req(input int ch, input logic [2:0] p);
		@(posedge sys_clk) channel_priority_field[ch*3 +: 3] <= p;
		irq_pending[ch] <= 1'b1;
	endtask : req

	task automatic pulse_ei;
		@(posedge sys_clk) enable_interrupts_op <= 1'b1;
		@(posedge sys_clk) enable_interrupts_op <= 1'b0;
	endtask : pulse_ei

	task automatic set_cpl(input logic [2:0] p);
		@(posedge sys_clk) cpl_wr <= 1'b1;
		cpl_wdata <= p;
		@(posedge sys_clk) cpl_wr <= 1'b0;
		@(negedge sys_clk);
		check("cpl_write", current_priority_level, p);
	endtask : set_cpl

	// One arbitration slot; the source drops its request once it is served
	task automatic take(input logic ack, input logic dma, input int ch);
		@(posedge sys_clk) instr_boundary <= 1'b1;
		@(negedge sys_clk);
		check("int_ack", int_ack, ack);
		check("dma_grant", dma_grant, dma);
		@(posedge sys_clk) instr_boundary <= 1'b0;
		if (ack || dma) begin
			irq_pending[ch] <= 1'b0;
			dma_pending[ch] <= 1'b0;
			top_level_req <= 1'b0;
		end
	endtask : take

	task automatic entry(input int ch, input logic [7:0] vec, input int n, input logic [7:0] cs,
			output logic [15:0] pc, output logic [7:0] fl);
		logic [3:0] sp0;
		int i;
		@(posedge sys_clk) pc_in <= pc_in + 16'h0111;
		flag_reg <= flag_reg + 8'h13;
		sp0 = i_cpu_stack_model.sp_ff;
		take(1'b1, 1'b0, ch);
		pc = pc_in;
		fl = flag_reg;
		@(negedge sys_clk);
		if (vec != 8'h04) check("grant_channel", grant_channel, ch[3:0]);
		check("ack_top_level", ack_top_level, vec == 8'h04);
		check("int_vector", int_vector, vec);
		check("ien_entry", global_int_enable, 1'b0);
		for (i = 0; i < 10 && vec_fetch !== 1'b1; i++) @(negedge sys_clk);
		check("vec_fetch", vec_fetch, 1'b1);
		check("vec_segment", fetch_segment, 8'h5a);
		check("push_count", i_cpu_stack_model.sp_ff - sp0, n);
		check("push_pcl", i_cpu_stack_model.mem_ff[sp0], pc[7:0]);
		check("push_pch", i_cpu_stack_model.mem_ff[sp0 + 4'h1], pc[15:8]);
		if (n == 4) check("push_cs", i_cpu_stack_model.mem_ff[sp0 + 4'h2], cs);
		check("push_flag", i_cpu_stack_model.mem_ff[sp0 + n - 1], fl);
		@(negedge sys_clk);
	endtask : entry

	task automatic leave(input logic [15:0] pc, input logic [7:0] fl);
		int i;
		@(posedge sys_clk) iret_req <= 1'b1;
		@(posedge sys_clk) iret_req <= 1'b0;
		@(negedge sys_clk);
		for (i = 0; i < 10 && ret_done !== 1'b1; i++) @(negedge sys_clk);
		check("ret_done", ret_done, 1'b1);
		check("ret_pc", ret_pc, pc);
		check("ret_flags", ret_flags, fl);
		@(negedge sys_clk);
		check("ien_ret", global_int_enable, 1'b1);
	endtask : leave

	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check("cpl_reset", current_priority_level, 3'h7);
		check("ien_reset", global_int_enable, 1'b0);
		check("nest_reset", nesting_priority_stack, 8'h00);
		@(posedge sys_clk) cs_wr <= 1'b1;
		@(posedge sys_clk) cs_wr <= 1'b0;
		req(4, 3'h2);
		take(1'b0, 1'b0, 4);
		pulse_ei;
		req(2, 3'h7);
		set_cpl(3'h3);
		entry(4, 8'ha8, 4, 8'h3c, pa, fa);
		check("cpl_conc", current_priority_level, 3'h3);
		check("cs_loaded", code_segment_reg, 8'h5a);
		pulse_ei;
		take(1'b0, 1'b0, 2);
		req(2, 3'h3);
		take(1'b0, 1'b0, 2);
		req(2, 3'h2);
		entry(2, 8'ha4, 4, 8'h5a, pb, fb);
		leave(pb, fb);
		check("cs_inner", code_segment_reg, 8'h5a);
		leave(pa, fa);
		check("cs_restored", code_segment_reg, 8'h3c);
		@(posedge sys_clk) segment_save_enable <= 1'b0;
		req(5, 3'h1);
		entry(5, 8'haa, 3, 8'h3c, pa, fa);
		check("isr_used", fetch_segment, 8'h5a);
		check("cs_kept", code_segment_reg, 8'h3c);
		leave(pa, fa);
		check("csr_back", fetch_segment, 8'h3c);
		req(1, 3'h1);
		req(6, 3'h1);
		entry(1, 8'ha2, 3, 8'h3c, pa, fa);
		@(posedge sys_clk) top_level_req <= 1'b1;
		top_level_nonmaskable <= 1'b1;
		entry(0, 8'h04, 3, 8'h3c, pb, fb);
		pulse_ei;
		take(1'b0, 1'b0, 6);
		leave(pb, fb);
		@(posedge sys_clk) channel_priority_field[2:0] <= 3'h0;
		dma_pending[0] <= 1'b1;
		take(1'b0, 1'b1, 0);
		entry(6, 8'hac, 3, 8'h3c, pb, fb);
		leave(pb, fb);
		leave(pa, fa);
		@(posedge sys_clk) arbitration_mode_select <= 1'b1;
		req(3, 3'h1);
		entry(3, 8'ha6, 3, 8'h3c, pa, fa);
		check("cpl_nest", current_priority_level, 3'h1);
		check("nest_mark", nesting_priority_stack, 8'h08);
		leave(pa, fa);
		check("cpl_pop", current_priority_level, 3'h3);
		check("nest_pop", nesting_priority_stack, 8'h00);
		// Maskable top request waits for the enable, then leaves the nested level alone
		@(posedge sys_clk) top_level_nonmaskable <= 1'b0;
		top_level_maskable <= 1'b1;
		req(7, 3'h2);
		entry(7, 8'hae, 3, 8'h3c, pa, fa);
		@(posedge sys_clk) top_level_req <= 1'b1;
		take(1'b0, 1'b0, 0);
		pulse_ei;
		entry(0, 8'h04, 3, 8'h3c, pb, fb);
		leave(pb, fb);
		check("cpl_top", current_priority_level, 3'h2);
		leave(pa, fa);
		check("cpl_back", current_priority_level, 3'h3);
		test_done;
	end

	// Whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		test_done;
	end
endmodule : tb_priority_interrupt_arbiter
`default_nettype wire
